// ### pkg/api_pkg.sv
// Purpose : Constants and types for the ancillary packet inserter
// Assumes : APB byte addresses, 32-bit data
// Notes   : Shared by the design and the bench

package api_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] A_CTRL     = 12'h000;
  localparam logic [11:0] A_DID      = 12'h004;
  localparam logic [11:0] A_SDID     = 12'h008;
  localparam logic [11:0] A_DC       = 12'h00C;
  localparam logic [11:0] A_CS       = 12'h010;
  localparam logic [11:0] A_LINE1    = 12'h014;
  localparam logic [11:0] A_LINE2    = 12'h018;
  localparam logic [11:0] A_OFFS     = 12'h01C;
  localparam logic [11:0] A_CLEAR    = 12'h020;
  localparam logic [11:0] A_STATUS   = 12'h024;
  localparam logic [1:0]  A_UDW_PAGE = 2'h1;    // Bits 11:10 of 0x400..0x7FC
  localparam logic [7:0]  UDW_WORDS  = 8'hFF;   // Indexes 000..254
  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_LO = 0;
  localparam int CTRL_PARMAN  = 2;
  localparam int CTRL_CSAUTO  = 3;
  localparam int CTRL_FLD_LO  = 4;
  localparam int CTRL_CHROMA  = 6;
  localparam int CTRL_LINKB   = 7;
  localparam int CTRL_STRM2   = 8;
  // ----------------------------------------------------------------
  // Encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_OFF    = 2'h0;
  localparam logic [1:0] MODE_CONT   = 2'h1;
  localparam logic [1:0] MODE_SINGLE = 2'h2;
  localparam logic [1:0] FLD_1       = 2'h0;
  localparam logic [1:0] FLD_2       = 2'h1;
  localparam logic [1:0] FLD_BOTH    = 2'h2;
  localparam logic [9:0] ADF_FIRST   = 10'h000;
  localparam logic [9:0] ADF_NEXT    = 10'h3FF;
  localparam logic [1:0] ADF_LAST    = 2'h2;
  localparam logic [9:0] RST_WORD    = 10'h000;
  localparam logic [10:0] RST_LINE   = 11'h000;
  localparam logic [11:0] RST_OFFS   = 12'h000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADF  = 3'b001,
    ST_DID  = 3'b010,
    ST_SDID = 3'b011,
    ST_DC   = 3'b100,
    ST_UDW  = 3'b101,
    ST_CS   = 3'b110
  } api_state_type;
endpackage

// ### hw/api_inserter.sv
// Purpose : Builds one ancillary packet and overlays it on the video stream
// Assumes : Upstream timing supplies line, field, sample-from-SAV and flags
// Notes   : Function
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/10ps

module api_inserter
  import api_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Format of the current raster
  input  wire logic        fmt_interlaced,
  input  wire logic        fmt_3gb,
  input  wire logic        fmt_2xhd,
  input  wire logic [10:0] fmt_line_max,
  input  wire logic [11:0] fmt_sample_max,
  // Incoming video word stream
  input  wire logic        vid_in_valid,
  input  wire logic [9:0]  vid_in_luma,
  input  wire logic [9:0]  vid_in_chroma,
  input  wire logic        vid_in_prot_luma,
  input  wire logic        vid_in_prot_chroma,
  input  wire logic [10:0] vid_in_line,
  input  wire logic        vid_in_field2,
  input  wire logic [11:0] vid_in_sample,
  input  wire logic        vid_in_link_b,
  input  wire logic        vid_in_stream2,
  // Outgoing video word stream
  output logic             vid_out_valid,
  output logic      [9:0]  vid_out_luma,
  output logic      [9:0]  vid_out_chroma,
  output logic             vid_out_inserted
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]          mode;
    logic                par_man;
    logic                cs_auto;
    logic [1:0]          fld_sel;
    logic                ch_chroma;
    logic                link_b;
    logic                strm2;
    logic [9:0]          did;
    logic [9:0]          sdid;
    logic [9:0]          dc;
    logic [9:0]          cs;
    logic [10:0]         line1;
    logic [10:0]         line2;
    logic [11:0]         offs;
    logic                armed;
    logic                done;
    api_state_type       st;
    logic [7:0]          cnt;
    logic [8:0]          sum;
    logic [15:0]         pkts;
    logic [31:0]         prdata;
    logic                out_valid;
    logic [9:0]          out_luma;
    logic [9:0]          out_chroma;
    logic                out_ins;
    logic [254:0][9:0]   udw;
  } api_regs_type;

  api_regs_type r_q;
  api_regs_type r_d;

  logic [9:0]  word_sel;
  logic        prot_sel;
  logic        adv;
  logic        loc_ok;
  logic        fld_ok;
  logic [10:0] tgt_line;
  logic        range_ok;
  logic        mode_ok;
  logic        start;
  logic        ins;
  api_state_type eff_st;
  logic [7:0]  eff_cnt;
  logic [9:0]  raw_word;
  logic [9:0]  pkt_word;
  logic [8:0]  sum_next;
  logic        acc;
  logic        wr;
  logic        udw_hit;
  logic        reg_hit;
  logic [7:0]  udw_idx;
  logic [31:0] rd_val;

  // Parity generation on the low eight bits
  function automatic logic [9:0] api_par(input logic [9:0] w);
    logic p;
    p = ^w[7:0];
    return {~p, p, w[7:0]};
  endfunction

  // ----------------------------------------------------------------
  // Position match
  // ----------------------------------------------------------------
  // Chosen channel and its protection flag
  assign word_sel = r_q.ch_chroma ? vid_in_chroma : vid_in_luma;
  assign prot_sel = r_q.ch_chroma ? vid_in_prot_chroma : vid_in_prot_luma;
  assign adv      = vid_in_valid & ~prot_sel;
  assign loc_ok   = (~fmt_3gb | (vid_in_link_b == r_q.link_b))
                  & (~fmt_2xhd | (vid_in_stream2 == r_q.strm2));
  // Field two carries its own line number in interlaced rasters
  assign tgt_line = (fmt_interlaced & vid_in_field2) ? r_q.line2 : r_q.line1;
  assign fld_ok   = ~fmt_interlaced
                  | (vid_in_field2 ? (r_q.fld_sel != FLD_1) : (r_q.fld_sel != FLD_2));
  assign range_ok = (tgt_line != RST_LINE) & (tgt_line <= fmt_line_max)
                  & (r_q.offs <= fmt_sample_max);
  assign mode_ok  = (r_q.mode == MODE_CONT) | ((r_q.mode == MODE_SINGLE) & r_q.armed);
  // First header word lands where the sample count from SAV hits the offset
  assign start    = adv & (r_q.st == ST_IDLE) & mode_ok & fld_ok & range_ok & loc_ok
                  & (vid_in_line == tgt_line) & (vid_in_sample == r_q.offs);
  assign ins      = start | ((r_q.st != ST_IDLE) & adv);

  // ----------------------------------------------------------------
  // Packet word selection
  // ----------------------------------------------------------------
  assign eff_st  = (r_q.st == ST_IDLE) ? ST_ADF : r_q.st;
  assign eff_cnt = (r_q.st == ST_IDLE) ? 8'h00 : r_q.cnt;

  // Raw word of the current packet position
  always_comb
  begin
    case (eff_st)
      ST_ADF:  raw_word = (eff_cnt == 8'h00) ? ADF_FIRST : ADF_NEXT;
      ST_DID:  raw_word = r_q.did;
      ST_SDID: raw_word = r_q.sdid;
      ST_DC:   raw_word = r_q.dc;
      ST_UDW:  raw_word = r_q.udw[eff_cnt];
      ST_CS:   raw_word = r_q.cs_auto ? {~r_q.sum[8], r_q.sum} : r_q.cs;
      default: raw_word = RST_WORD;
    endcase
  end

  // Parity applied in automatic mode, except to the ADF flag words and computed checksum
  always_comb
  begin
    if (r_q.par_man || eff_st == ST_ADF || (eff_st == ST_CS && r_q.cs_auto))
      pkt_word = raw_word;
    else
      pkt_word = api_par(raw_word);
  end

  assign sum_next = (eff_st == ST_DID) ? pkt_word[8:0] : r_q.sum + pkt_word[8:0];

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign acc     = psel & penable;
  assign wr      = acc & pwrite;
  assign udw_idx = paddr[9:2];
  assign udw_hit = (paddr[11:10] == A_UDW_PAGE) & (udw_idx < UDW_WORDS);
  assign reg_hit = (paddr[11:6] == 6'h00) & ({paddr[11:2], 2'h0} <= A_STATUS);
  assign pready  = acc;
  assign pslverr = acc & ~(udw_hit | reg_hit);

  // Read multiplexer
  always_comb
  begin
    rd_val = 32'h0000_0000;
    if (udw_hit)
      rd_val = {22'h000000, r_q.udw[udw_idx]};
    else
      case ({paddr[11:2], 2'h0})
        A_CTRL:   rd_val = {23'h000000, r_q.strm2, r_q.link_b, r_q.ch_chroma,
                            r_q.fld_sel, r_q.cs_auto, r_q.par_man, r_q.mode};
        A_DID:    rd_val = {22'h000000, r_q.did};
        A_SDID:   rd_val = {22'h000000, r_q.sdid};
        A_DC:     rd_val = {22'h000000, r_q.dc};
        A_CS:     rd_val = {22'h000000, r_q.cs};
        A_LINE1:  rd_val = {21'h000000, r_q.line1};
        A_LINE2:  rd_val = {21'h000000, r_q.line2};
        A_OFFS:   rd_val = {20'h00000, r_q.offs};
        A_STATUS: rd_val = {r_q.pkts, 13'h0000, r_q.done, r_q.armed,
                            (r_q.st != ST_IDLE)};
        default:  rd_val = 32'h0000_0000;
      endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    r_d = r_q;
    // Register writes keep all ten bits
    if (wr && udw_hit)
      r_d.udw[udw_idx] = pwdata[9:0];
    if (wr && reg_hit)
      case ({paddr[11:2], 2'h0})
        A_CTRL:
        begin
          r_d.mode      = pwdata[CTRL_MODE_LO +: 2];
          r_d.par_man   = pwdata[CTRL_PARMAN];
          r_d.cs_auto   = pwdata[CTRL_CSAUTO];
          r_d.fld_sel   = pwdata[CTRL_FLD_LO +: 2];
          r_d.ch_chroma = pwdata[CTRL_CHROMA];
          r_d.link_b    = pwdata[CTRL_LINKB];
          r_d.strm2     = pwdata[CTRL_STRM2];
          r_d.armed     = (pwdata[CTRL_MODE_LO +: 2] == MODE_SINGLE);
          r_d.done      = 1'b0;
        end
        A_DID:   r_d.did   = pwdata[9:0];
        A_SDID:  r_d.sdid  = pwdata[9:0];
        A_DC:    r_d.dc    = pwdata[9:0];
        A_CS:    r_d.cs    = pwdata[9:0];
        A_LINE1: r_d.line1 = pwdata[10:0];
        A_LINE2: r_d.line2 = pwdata[10:0];
        A_OFFS:  r_d.offs  = pwdata[11:0];
        A_CLEAR:
        begin
          if (pwdata[0])
            r_d.udw = '0;
        end
        default: r_d.cnt = r_q.cnt;
      endcase
    // Read data captured in the setup cycle
    if (psel && !penable)
      r_d.prdata = rd_val;
    // Single shot disarms on its own start
    if (start && r_q.mode == MODE_SINGLE)
    begin
      r_d.armed = 1'b0;
      r_d.done  = 1'b1;
    end
    // Packet sequencer advances only on words it may replace
    if (ins)
      case (eff_st)
        ST_ADF:
        begin
          r_d.st  = (eff_cnt == {6'h00, ADF_LAST}) ? ST_DID : ST_ADF;
          r_d.cnt = eff_cnt + 8'h01;
        end
        ST_DID:
        begin
          r_d.st  = ST_SDID;
          r_d.sum = sum_next;
        end
        ST_SDID:
        begin
          r_d.st  = ST_DC;
          r_d.sum = sum_next;
        end
        ST_DC:
        begin
          r_d.st  = (r_q.dc[7:0] == 8'h00) ? ST_CS : ST_UDW;
          r_d.cnt = 8'h00;
          r_d.sum = sum_next;
        end
        ST_UDW:
        begin
          r_d.st  = (r_q.cnt == r_q.dc[7:0] - 8'h01) ? ST_CS : ST_UDW;
          r_d.cnt = r_q.cnt + 8'h01;
          r_d.sum = sum_next;
        end
        ST_CS:
        begin
          r_d.st   = ST_IDLE;
          r_d.pkts = r_q.pkts + 16'h0001;
        end
        default: r_d.st = ST_IDLE;
      endcase
    // Output overlay on the selected channel
    r_d.out_valid  = vid_in_valid;
    r_d.out_luma   = (ins && !r_q.ch_chroma) ? pkt_word : vid_in_luma;
    r_d.out_chroma = (ins && r_q.ch_chroma) ? pkt_word : vid_in_chroma;
    r_d.out_ins    = ins;
  end

  // State register with synchronous reset
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      r_q       <= '0;
      r_q.st    <= ST_IDLE;
      r_q.mode  <= MODE_OFF;
      r_q.line1 <= RST_LINE;
      r_q.line2 <= RST_LINE;
      r_q.offs  <= RST_OFFS;
    end
    else
      r_q <= r_d;
  end

  assign prdata           = r_q.prdata;
  assign vid_out_valid    = r_q.out_valid;
  assign vid_out_luma     = r_q.out_luma;
  assign vid_out_chroma   = r_q.out_chroma;
  assign vid_out_inserted = r_q.out_ins;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [9:0] out_sel;
  assign out_sel = r_q.ch_chroma ? r_q.out_chroma : r_q.out_luma;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_dc_taken;
    (r_q.st == ST_DC) && adv;
  endsequence
  sequence s_zero_count;
    r_q.dc[7:0] == 8'h00;
  endsequence

  AST_PROTECTED_PASS: assert property (
    vid_in_valid && prot_sel |=> !r_q.out_ins && out_sel == $past(word_sel))
    else $error("Protected word was overwritten");
  AST_HEADER_ORDER: assert property (
    (r_q.st == ST_DID) && adv |=> r_q.st == ST_SDID && r_q.sum == $past(sum_next))
    else $error("Identifier not followed by secondary identifier");
  AST_COUNT_EMPTY: assert property (
    s_dc_taken ##0 s_zero_count |=> r_q.st == ST_CS)
    else $error("Empty packet did not go to checksum");
  AST_COUNT_WORDS: assert property (
    s_dc_taken ##0 (r_q.dc[7:0] != 8'h00) |=> r_q.st == ST_UDW && r_q.cnt == 8'h00)
    else $error("User words did not start at index zero");
  AST_CLEAR_ALL: assert property (
    wr && reg_hit && {paddr[11:2], 2'h0} == A_CLEAR && pwdata[0] |=> r_q.udw == '0)
    else $error("Confirmed clear left data in store");
  AST_CLEAR_CANCEL: assert property (
    wr && {paddr[11:2], 2'h0} == A_CLEAR && !pwdata[0] |=> $stable(r_q.udw))
    else $error("Cancelled clear changed the store");
  AST_DISABLED_IDLE: assert property (
    r_q.st == ST_IDLE && r_q.mode == MODE_OFF |=> !r_q.out_ins)
    else $error("Insertion while disabled");
  AST_SINGLE_DISARM: assert property (
    start && r_q.mode == MODE_SINGLE |=> !r_q.armed && r_q.done)
    else $error("Single packet did not disarm");
  AST_AUTO_PARITY: assert property (
    ins && !r_q.par_man && eff_st != ST_ADF && !(eff_st == ST_CS && r_q.cs_auto) |=>
      out_sel[8] == ^out_sel[7:0] && out_sel[9] == ~out_sel[8])
    else $error("Generated parity wrong");
  AST_RANGE_GATE: assert property (
    start |-> tgt_line <= fmt_line_max && r_q.offs <= fmt_sample_max)
    else $error("Insertion outside raster range");
  AST_CS_MANUAL: assert property (
    r_q.st == ST_CS && adv && !r_q.cs_auto && r_q.par_man |=> out_sel == $past(r_q.cs))
    else $error("Programmed checksum not sent");

endmodule

// ### testbench/api_video_src.sv
// Purpose : Raster source model feeding the inserter
// Assumes : One word per clock, 4 lines of 64 samples per frame
// Notes   : Frame count bits give field, link and substream flags
`timescale 1ns/10ps

module api_video_src
  import api_pkg::*;
(
  // Clock, reset and bench control
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic [11:0] prot_at,
  input  wire logic        prot_ch,
  // Word stream
  output logic             v_val,
  output logic      [9:0]  v_l,
  output logic      [9:0]  v_c,
  output logic             v_prl,
  output logic             v_prc,
  output logic      [10:0] v_line,
  output logic      [11:0] v_samp,
  output logic      [7:0]  frm
);
  logic [5:0] samp_q;
  logic [1:0] line_q;

  // Sample, line and frame counters
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      samp_q <= 6'h00;
      line_q <= 2'h0;
      frm    <= 8'h00;
    end
    else
    begin
      samp_q <= samp_q + 6'h01;
      if (samp_q == 6'h3F)
        line_q <= line_q + 2'h1;
      if (samp_q == 6'h3F && line_q == 2'h3)
        frm <= frm + 8'h01;
    end
  end

  // Words change every cycle so a stale word never passes for a fresh one
  assign v_val  = !reset;
  assign v_samp = {6'h00, samp_q};
  assign v_line = {9'h000, line_q} + 11'h001;
  assign v_l    = {line_q, samp_q, frm[1:0]};
  assign v_c    = ~v_l;
  assign v_prl  = (v_samp == prot_at) && !prot_ch;
  assign v_prc  = (v_samp == prot_at) && prot_ch;
endmodule

// ### testbench/test_api_inserter.sv
// Purpose : Self-checking bench for the ancillary packet inserter
// Assumes : 50 MHz clock, zero-wait APB, 4x64 raster from the source model
// Notes   : Expected packet words wait in a queue until the monitor sees them
`timescale 1ns/10ps

`define CHK(got, exp) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module test_api_inserter
  import api_pkg::*;
;
  logic        ref_clk, pready, pslverr, err, o_val, o_ins, v_val, v_prl, v_prc;
  logic        reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sel_c = 1'b0;
  logic        f_il = 1'b0, f_3gb = 1'b0, f_2hd = 1'b0, prot_ch = 1'b0;
  logic [11:0] paddr = 12'h000, prot_at = 12'hFFF, offs_max = 12'h028, offs_m = 12'h003;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [10:0] line_max = 11'h004, v_line;
  logic [9:0]  v_l, v_c, o_l, o_c, e_w, r_l, r_c;
  logic [11:0] v_samp, r_samp;
  logic [7:0]  frm;
  logic        r_ok, r_val, r_prl, r_prc, r_ins, r_gap;
  logic [31:0] st_rd;
  logic [9:0]  udw_m [0:254];
  logic [9:0]  pk_m [0:3];
  logic [9:0]  exp_q [$];
  logic [15:0] lfsr_s = 16'h0002;
  int          errors = 0;
  int          n_checks = 0;

  api_inserter dut (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fmt_interlaced(f_il), .fmt_3gb(f_3gb), .fmt_2xhd(f_2hd), .fmt_line_max(line_max),
    .fmt_sample_max(offs_max), .vid_in_valid(v_val), .vid_in_luma(v_l), .vid_in_chroma(v_c),
    .vid_in_prot_luma(v_prl), .vid_in_prot_chroma(v_prc), .vid_in_line(v_line),
    .vid_in_field2(frm[0]), .vid_in_sample(v_samp), .vid_in_link_b(frm[0]),
    .vid_in_stream2(frm[1]), .vid_out_valid(o_val), .vid_out_luma(o_l),
    .vid_out_chroma(o_c), .vid_out_inserted(o_ins));
  api_video_src src (
    .ref_clk(ref_clk), .reset(reset), .prot_at(prot_at), .prot_ch(prot_ch), .v_val(v_val),
    .v_l(v_l), .v_c(v_c), .v_prl(v_prl), .v_prc(v_prc), .v_line(v_line), .v_samp(v_samp),
    .frm(frm));

  // 50 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Even parity in bit 8, its inverse in bit 9
  function automatic logic [9:0] par(input logic [9:0] w);
    return {~(^w[7:0]), ^w[7:0], w[7:0]};
  endfunction

  // Pseudo-random 10-bit values
  function automatic logic [9:0] rnd();
    lfsr_s = {lfsr_s[14:0], lfsr_s[15] ^ lfsr_s[13] ^ lfsr_s[12] ^ lfsr_s[10]};
    return lfsr_s[9:0];
  endfunction

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    // Wait states, if any, last until pready goes high; a transfer that never ends is stopped by the watchdog
    while (pready !== 1'b1)
      @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic set_udw(input logic [7:0] i, input logic [9:0] v);
    udw_m[i] = v;
    apb(1'b1, {A_UDW_PAGE, i, 2'b00}, {22'h0, v});
  endtask

  // Identifier, secondary identifier, count and checksum registers
  task automatic cfg(input logic [9:0] did, sdid, dc, cs);
    pk_m = '{did, sdid, dc, cs};
    for (int k = 0; k < 4; k++)
      apb(1'b1, A_DID + 12'(4 * k), {22'h0, pk_m[k]});
  endtask

  // Expected packet words for one insertion
  task automatic push_pkt(input logic [9:0] ctl);
    logic [9:0] w [$];
    logic [8:0] sum;
    w = '{ADF_FIRST, ADF_NEXT, ADF_NEXT, pk_m[0], pk_m[1], pk_m[2]};
    for (int i = 0; i < pk_m[2][7:0]; i++)
      w.push_back(udw_m[i]);
    sum = 9'h000;
    for (int i = 3; i < w.size(); i++)
    begin
      if (!ctl[CTRL_PARMAN])
        w[i] = par(w[i]);
      sum = sum + w[i][8:0];
    end
    w.push_back(ctl[CTRL_CSAUTO] ? {~sum[8], sum} : (ctl[CTRL_PARMAN] ? pk_m[3] : par(pk_m[3])));
    exp_q = {exp_q, w};
  endtask

  // Arm at a frame start, let frames pass, disarm and expect every packet seen
  task automatic run(input logic [9:0] ctl, input int frames, input int npk);
    @(posedge ref_clk);
    while (v_samp !== 12'h000 || v_line !== 11'h001)
      @(posedge ref_clk);
    sel_c = ctl[CTRL_CHROMA];
    repeat (npk)
      push_pkt(ctl);
    apb(1'b1, A_CTRL, {22'h0, ctl});
    repeat (frames * 256 - 8)
      @(posedge ref_clk);
    // Status is sampled before the disarm write clears the done flag
    apb(1'b0, A_STATUS, 32'h0);
    st_rd = rd;
    apb(1'b1, A_CTRL, 32'h0);
    repeat (30)
      @(posedge ref_clk);
    `CHK(exp_q.size(), 0)
  endtask

  // Each output word is the delayed input or the oldest expected packet word
  always @(posedge ref_clk)
  begin
    if (r_ok === 1'b1)
    begin
      `CHK(o_val, r_val)
      if ((r_prl && !sel_c) || (r_prc && sel_c))
        `CHK(o_ins, 1'b0)
      // A packet resumed after a protected word is not a new start
      if (o_ins === 1'b1 && r_ins !== 1'b1 && r_gap !== 1'b1)
        `CHK(r_samp, offs_m)
      e_w = 10'h000;
      if (o_ins === 1'b1 && exp_q.size() == 0)
        `CHK(o_ins, 1'b0)
      else if (o_ins === 1'b1)
        e_w = exp_q.pop_front();
      `CHK(o_l, (o_ins === 1'b1 && !sel_c) ? e_w : r_l)
      `CHK(o_c, (o_ins === 1'b1 && sel_c) ? e_w : r_c)
    end
    r_ok   <= !reset;
    r_val  <= v_val;
    r_prl  <= v_prl;
    r_prc  <= v_prc;
    r_l    <= v_l;
    r_c    <= v_c;
    r_ins  <= o_ins;
    r_gap  <= (r_prl && !sel_c) || (r_prc && sel_c);
    r_samp <= v_samp;
  end

  // Main sequence
  initial
  begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    apb(1'b0, A_CTRL, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b1, A_STATUS + 12'h004, 32'h1);
    `CHK(err, 1'b1)
    apb(1'b0, 12'h7FC, 32'h0);
    `CHK({err, rd}, 33'h100000000)
    set_udw(8'hFE, 10'h3A5);
    apb(1'b0, 12'h7F8, 32'h0);
    `CHK(rd, 32'h3A5)
    for (int i = 0; i < 8; i++)
      set_udw(i[7:0], rnd());
    cfg(10'h241, 10'h105, 10'h304, 10'h2AA);
    apb(1'b0, A_DC, 32'h0);
    `CHK(rd, 32'h304)
    apb(1'b1, A_LINE1, 32'h2);
    apb(1'b1, A_LINE2, 32'h3);
    apb(1'b1, A_OFFS, 32'h3);
    run(10'h009, 2, 2);
    prot_at <= 12'h006;
    prot_ch <= 1'b1;
    run(10'h045, 1, 1);
    prot_ch <= 1'b0;
    prot_at <= 12'h005;
    run(10'h00D, 1, 1);
    prot_at <= 12'hFFF;
    run(10'h002, 2, 1);
    `CHK(st_rd[2:1], 2'b10)
    `CHK(st_rd[31:16], 16'h0005)
    run(10'h000, 1, 0);
    run(10'h003, 1, 0);
    f_il <= 1'b1;
    run(10'h011, 2, 1);
    run(10'h021, 2, 2);
    f_il  <= 1'b0;
    f_3gb <= 1'b1;
    run(10'h081, 2, 1);
    f_3gb <= 1'b0;
    f_2hd <= 1'b1;
    run(10'h101, 4, 2);
    f_2hd <= 1'b0;
    apb(1'b1, A_LINE1, 32'h4);
    run(10'h001, 1, 1);
    line_max <= 11'h003;
    run(10'h001, 1, 0);
    line_max <= 11'h004;
    apb(1'b1, A_LINE1, 32'h2);
    apb(1'b1, A_OFFS, 32'h29);
    run(10'h001, 1, 0);
    apb(1'b1, A_OFFS, 32'h28);
    offs_m = 12'h028;
    run(10'h001, 1, 1);
    apb(1'b1, A_CLEAR, 32'h0);
    apb(1'b0, 12'h400, 32'h0);
    `CHK(rd[9:0], udw_m[0])
    apb(1'b1, A_CLEAR, 32'h1);
    apb(1'b0, 12'h7F8, 32'h0);
    `CHK(rd, 32'h0)
    for (int i = 0; i < 255; i++)
      udw_m[i] = 10'h000;
    cfg(10'h041, 10'h005, 10'h008, 10'h000);
    run(10'h009, 1, 1);
    cfg(10'h041, 10'h005, 10'h000, 10'h0C3);
    run(10'h001, 1, 1);
    end_sim();
  end

  // Watchdog: the whole sequence needs about 10300 cycles
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    errors++;
    end_sim();
  end

  task end_sim();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
endmodule
